// >>> hw/rstsrc_filter.sv
// persistence filter: output rises once input has stayed high for a minimum count
`timescale 1ns/10ps
module rstsrc_filter #(
  parameter int unsigned W   = 8,
  parameter int unsigned MIN = 1
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic lvl_i,
  output logic      hit_o
);
  logic [W-1:0] cnt_r;

  // count while the level holds, restart on any gap
  always_ff @(posedge clk_i) begin
    if (rst_i || !lvl_i) begin
      cnt_r <= '0;
    end else if (cnt_r != W'(MIN)) begin
      cnt_r <= cnt_r + W'(1);
    end
  end

  // short dips never reach the limit
  assign hit_o = lvl_i && (cnt_r == W'(MIN));
endmodule

// >>> hw/rstsrc_pkg.sv
// package of constants for the reset source tracking block
package rstsrc_pkg;
  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int unsigned CLK_HZ             = 40_000_000;
  localparam int unsigned STARTUP_TIMEOUT_US = 65000;  // start-up timeout period, plain default
  localparam int unsigned STARTUP_CYCLES     = (STARTUP_TIMEOUT_US * (CLK_HZ / 1_000_000));
  localparam int unsigned DROP_MIN_TIME_NS   = 2000;   // drop detection min time, plain default
  localparam int unsigned DROP_MIN_CYCLES    = (DROP_MIN_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned PIN_MIN_PULSE_NS   = 2500;   // reset pin min pulse, plain default
  localparam int unsigned PIN_MIN_CYCLES     = (PIN_MIN_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned CNT_W              = 24;
  localparam int unsigned FLT_W              = 8;

  // ************************************************************
  // register map (word offsets in bytes)
  // ************************************************************
  localparam logic [3:0] ADDR_CAUSE  = 4'h0;
  localparam logic [3:0] ADDR_CTRL   = 4'h4;
  localparam logic [3:0] ADDR_IRQ_ST = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MK = 4'hc;

  // cause flag bit positions
  localparam int unsigned BIT_POR  = 0;
  localparam int unsigned BIT_PIN  = 1;
  localparam int unsigned BIT_DROP = 2;
  localparam int unsigned BIT_WDT  = 3;
  localparam int unsigned BIT_TEST = 4;
  localparam int unsigned NCAUSE   = 5;

  // control bit positions
  localparam int unsigned BIT_CMP_BG = 0;
  localparam int unsigned BIT_CONV   = 1;
  localparam int unsigned BIT_RUN    = 2;

  localparam logic [NCAUSE-1:0] CAUSE_RST = 5'h01;
  localparam logic [NCAUSE-1:0] ZERO5     = 5'h00;

  typedef enum logic [1:0] {
    RSTSRC_HOLD = 2'b00,
    RSTSRC_WAIT = 2'b01,
    RSTSRC_RUN  = 2'b10
  } rstsrc_state_t;
endpackage

// >>> hw/rstsrc_top.sv
// reset source tracking: cause flags, start-up delay, bandgap enable, wishbone slave
// ************************************************************
// ************************************************************
//
// The Wishbone interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps
module rstsrc_top
  import rstsrc_pkg::*;
#(
  parameter int unsigned STARTUP_CNT = rstsrc_pkg::STARTUP_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        por_i,
  input  wire logic        reset_pin_n_i,
  input  wire logic        wdt_expire_i,
  input  wire logic        test_port_reset_instruction_i,
  input  wire logic        drop_det_en_fuse_i,
  input  wire logic        supply_low_i,
  input  wire logic        supply_ok_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             core_reset_o,
  output logic             wdt_reset_pulse_o,
  output logic             bandgap_en_o,
  output logic             irq_o
);
  import rstsrc_pkg::*;

  // ************************************************************
  // reset sources
  // ************************************************************
  logic              pin_hit;
  logic              drop_hit;
  logic              wdt_pulse_r;
  logic              wdt_pulse_d_r;
  logic              drop_active_r;
  logic              any_src;
  logic              wdt_fall;
  logic [NCAUSE-1:0] cause_r;
  logic [NCAUSE-1:0] ev;
  logic [NCAUSE-1:0] irq_st_r;
  logic [NCAUSE-1:0] irq_mk_r;
  logic [2:0]        ctrl_r;
  logic [CNT_W-1:0]  dly_r;
  rstsrc_state_t     state_r;
  logic              wr;
  logic              rd;

  // pin low must persist; filter ignores short glitches
  rstsrc_filter #(.W(FLT_W), .MIN(PIN_MIN_CYCLES)) u_pin_flt (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .lvl_i (!reset_pin_n_i),
    .hit_o (pin_hit)
  );

  // supply low must outlast the minimum detection time
  rstsrc_filter #(.W(FLT_W), .MIN(DROP_MIN_CYCLES)) u_drop_flt (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .lvl_i (supply_low_i && drop_det_en_fuse_i),
    .hit_o (drop_hit)
  );

  // watchdog pulse: one cycle after expiry is seen high while the sequencer is in run
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_pulse_r   <= 1'b0;
      wdt_pulse_d_r <= 1'b0;
    end else begin
      wdt_pulse_r   <= wdt_expire_i && !wdt_pulse_r && (state_r == RSTSRC_RUN);
      wdt_pulse_d_r <= wdt_pulse_r;
    end
  end
  assign wdt_fall          = wdt_pulse_d_r && !wdt_pulse_r;
  assign wdt_reset_pulse_o = wdt_pulse_r;

  // brown-out held from detection until the supply is back up
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      drop_active_r <= 1'b0;
    end else if (drop_hit) begin
      drop_active_r <= 1'b1;
    end else if (supply_ok_i || !drop_det_en_fuse_i) begin
      drop_active_r <= 1'b0;
    end
  end

  assign any_src = por_i || pin_hit || drop_hit || drop_active_r
                 || wdt_pulse_r || test_port_reset_instruction_i;

  // ************************************************************
  // start-up delay sequencer
  // ************************************************************
  // held sources keep the counter parked; timeout starts once all are gone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= RSTSRC_HOLD;
      dly_r   <= '0;
    end else begin
      case (state_r)
        RSTSRC_HOLD: begin
          dly_r <= '0;
          if (!any_src && !wdt_pulse_d_r) begin
            state_r <= RSTSRC_WAIT;
          end
        end
        RSTSRC_WAIT: begin
          if (any_src) begin
            state_r <= RSTSRC_HOLD;
          end else if (dly_r == CNT_W'(STARTUP_CNT - 1)) begin
            state_r <= RSTSRC_RUN;
          end else begin
            dly_r <= dly_r + CNT_W'(1);
          end
        end
        RSTSRC_RUN: begin
          if (any_src) begin
            state_r <= RSTSRC_HOLD;
          end
        end
        default: state_r <= RSTSRC_HOLD;
      endcase
    end
  end
  // core stays held through the timeout after each source
  // the pulse cycle itself holds the core, before the sequencer has left run
  assign core_reset_o = (state_r != RSTSRC_RUN) || wdt_pulse_r || wdt_fall;

  // ************************************************************
  // cause flags
  // ************************************************************
  always_comb begin
    ev           = ZERO5;
    ev[BIT_POR]  = por_i;
    ev[BIT_PIN]  = pin_hit;
    ev[BIT_DROP] = drop_hit;
    ev[BIT_WDT]  = wdt_pulse_r;
    ev[BIT_TEST] = test_port_reset_instruction_i;
  end

  // writes land at the edge where the master samples ack high
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

  // set wins over a same-cycle software clear; ones written are ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cause_r <= CAUSE_RST;
    end else if (por_i) begin
      cause_r <= CAUSE_RST;
    end else begin
      if (wr && wb_adr_i == ADDR_CAUSE && wb_sel_i[0]) begin
        cause_r <= (cause_r & wb_dat_i[NCAUSE-1:0]) | ev;
      end else begin
        cause_r <= cause_r | ev;
      end
    end
  end

  // ************************************************************
  // control, bandgap and interrupts
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r   <= 3'h0;
      irq_mk_r <= ZERO5;
    end else if (wr && wb_sel_i[0]) begin
      if (wb_adr_i == ADDR_CTRL) begin
        ctrl_r <= wb_dat_i[2:0];
      end
      if (wb_adr_i == ADDR_IRQ_MK) begin
        irq_mk_r <= wb_dat_i[NCAUSE-1:0];
      end
    end
  end

  // reference powered only when a user needs it, to save supply current
  assign bandgap_en_o = drop_det_en_fuse_i || ctrl_r[BIT_CMP_BG] || ctrl_r[BIT_CONV];

  // status cleared by a read; a new event in that cycle still lands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_st_r <= ZERO5;
    end else if (rd && wb_adr_i == ADDR_IRQ_ST) begin
      irq_st_r <= ev;
    end else begin
      irq_st_r <= irq_st_r | ev;
    end
  end
  assign irq_o = |(irq_st_r & irq_mk_r);

  // ************************************************************
  // wishbone slave: ack one cycle after strobe
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= 32'h0000_0000;
      if (rd) begin
        case (wb_adr_i)
          ADDR_CAUSE:  wb_dat_o <= {27'h0, cause_r};
          ADDR_CTRL:   wb_dat_o <= {29'h0, (state_r == RSTSRC_RUN), ctrl_r[1:0]};
          ADDR_IRQ_ST: wb_dat_o <= {27'h0, irq_st_r};
          ADDR_IRQ_MK: wb_dat_o <= {27'h0, irq_mk_r};
          default:     wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// >>> testbench/rstsrc_props.sv
// port checker for the reset source tracking block
`timescale 1ns/10ps
module rstsrc_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  input wire logic wdt_expire_i,
  input wire logic drop_det_en_fuse_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic core_reset_o,
  input wire logic wdt_reset_pulse_o,
  input wire logic bandgap_en_o
);
  // ************************************************************
  // properties, one clock domain
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_pulse_one_cycle: assert property (wdt_reset_pulse_o |=> !wdt_reset_pulse_o)
    else $error("watchdog pulse longer than one cycle");
  a_pulse_from_expiry: assert property ($rose(wdt_expire_i) && !core_reset_o |-> ##[1:2] wdt_reset_pulse_o)
    else $error("watchdog expiry gave no pulse");
  a_pulse_needs_expiry: assert property ($rose(wdt_reset_pulse_o) |-> $past(wdt_expire_i))
    else $error("watchdog pulse without expiry");
  a_pulse_holds_core: assert property ($fell(wdt_reset_pulse_o) |-> core_reset_o [*8])
    else $error("core released too soon after watchdog pulse");
  a_release_waits: assert property ($rose(core_reset_o) |=> core_reset_o [*8])
    else $error("core released before start-up delay");
  a_fuse_bandgap: assert property (drop_det_en_fuse_i |-> bandgap_en_o)
    else $error("bandgap off with detection fused on");
  a_por_holds: assert property (por_i |=> core_reset_o)
    else $error("power-on did not hold the core");
  // bus handshake, latency as handed over
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_needs_req: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
endmodule
bind rstsrc_top rstsrc_props u_props (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .wdt_expire_i(wdt_expire_i),
  .drop_det_en_fuse_i(drop_det_en_fuse_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .core_reset_o(core_reset_o), .wdt_reset_pulse_o(wdt_reset_pulse_o), .bandgap_en_o(bandgap_en_o));

// >>> testbench/rstsrc_top_test.sv
// self-checking bench for the reset source tracking block
`timescale 1ns/10ps
module rstsrc_top_test;
  import rstsrc_pkg::*;
  logic        clk_i = 0, rst_i = 1, por = 0, pin_n = 1, wdt = 0, tst = 0, fuse = 0, low = 0, ok = 1;
  logic        cyc = 0, stb = 0, we = 0, ack, core, pulse, bg, irq;
  logic [3:0]  adr = 0, sel = 0;
  logic [31:0] dat = 0, rdat, e;
  logic [7:0]  rnd = 8'h31;
  logic [4:0]  b;
  logic [31:0] expq[$];
  int          fail_count = 0, samples_checked = 0, n;
  always #12.5 clk_i = ~clk_i;
  // short start-up count keeps the run brief
  rstsrc_top #(.STARTUP_CNT(20)) dut (.clk_i(clk_i), .rst_i(rst_i), .por_i(por), .reset_pin_n_i(pin_n),
    .wdt_expire_i(wdt), .test_port_reset_instruction_i(tst), .drop_det_en_fuse_i(fuse), .supply_low_i(low),
    .supply_ok_i(ok), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .core_reset_o(core), .wdt_reset_pulse_o(pulse),
    .bandgap_en_o(bg), .irq_o(irq));
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
    samples_checked++;
    if (s !== x) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, x, s);
    end
  endtask
  // one classic cycle; held until ack is seen at a falling edge, released at the next rising edge
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do @(negedge clk_i); while (ack !== 1'b1);
    @(posedge clk_i);
    cyc <= 0;
    stb <= 0;
    we  <= 0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] x);
    expq.push_back(x);
    wb(a, 1'b0, 32'h0);
  endtask
  // waits for the core to leave reset, counting held cycles
  task automatic settle();
    n = 0;
    @(negedge clk_i);
    while (core !== 1'b0 && n < 500) begin
      @(negedge clk_i);
      n++;
    end
  endtask
  // read data watcher; an unknown note means the value is not predicted
  always @(negedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) begin
      e = expq.pop_front();
      if (e !== 32'hx) chk("read_data", e, rdat);
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #150000;
    fail_count++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    settle();
    rd(ADDR_CAUSE, 32'h1);
    rd(4'h2, 32'h0);
    rd(ADDR_CTRL, 32'h4);
    rd(ADDR_IRQ_ST, 32'hx);
    // every mix of the three bandgap demands
    for (int i = 0; i < 8; i++) begin
      fuse <= i[2];
      wb(ADDR_CTRL, 1'b1, i & 3);
      @(negedge clk_i);
      chk("bandgap", {31'h0, |i[2:0]}, {31'h0, bg});
    end
    wb(ADDR_CTRL, 1'b1, 32'h0);
    // one reset source per pass: k is also its flag position
    for (int k = 1; k < 5; k++) begin
      wb(ADDR_CAUSE, 1'b1, 32'h0);
      rnd = lfsr(rnd);
      wb(ADDR_IRQ_MK, 1'b1, {24'h0, rnd});
      case (k)
        1: begin
          pin_n <= 0;
          repeat (110) @(posedge clk_i);
          pin_n <= 1;
        end
        2: begin
          low <= 1;
          ok  <= 0;
          repeat (40) @(posedge clk_i);
          low <= 0;
          @(negedge clk_i);
          chk("short_dip", 32'h0, {31'h0, core});
          @(posedge clk_i);
          low <= 1;
          repeat (100) @(posedge clk_i);
          chk("drop_hold", 32'h1, {31'h0, core});
          low <= 0;
          ok  <= 1;
        end
        3: begin
          wdt <= 1;
          @(posedge clk_i);
          wdt <= 0;
        end
        default: begin
          tst <= 1;
          repeat (3) @(posedge clk_i);
          tst <= 0;
        end
      endcase
      settle();
      chk("held_cycles", 32'h1, {31'h0, (n >= 20) && (n < 500)});
      b = 5'h1 << k;
      rd(ADDR_CAUSE, {27'h0, b});
      @(negedge clk_i);
      chk("irq", {31'h0, |(b & rnd[4:0])}, {31'h0, irq});
      rd(ADDR_IRQ_ST, {27'h0, b});
      @(negedge clk_i);
      chk("irq_cleared", 32'h0, {31'h0, irq});
      rnd = lfsr(rnd);
      wb(ADDR_CAUSE, 1'b1, {24'h0, rnd});
      rd(ADDR_CAUSE, {27'h0, b & rnd[4:0]});
    end
    // power-on clears the other flags and sets its own
    wdt <= 1;
    @(posedge clk_i);
    wdt <= 0;
    settle();
    por <= 1;
    @(posedge clk_i);
    por <= 0;
    settle();
    rd(ADDR_CAUSE, 32'h1);
    repeat (3) @(posedge clk_i);
    summarize();
  end
endmodule
